// ===== bench/pmusbc_host.sv
// Host model: issues one-cycle register strobes and notes expected read data.
// Assumes the bench pops exp_q when read data appears.
`timescale 1ns/1ns
module pmusbc_host (
    // Clock
    input wire logic core_clk,
    // Register access
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$]; // Expected read bytes, oldest first
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One write; released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One read with its expected byte
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// ===== bench/pmusbc_regs_assertions.sv
// Checker: port relations of the system and buck register bank.
// Assumes a single core_clk domain with a synchronous active-high reset.
`timescale 1ns/1ns
module pmusbc_regs_chk #(
    parameter int VCODE_W = 6,
    parameter int NBUCK = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Monitors and pin
    input wire logic battery_low_live,
    input wire logic battery_event,
    input wire logic [NBUCK-1:0] power_ok,
    input wire logic voltage_select_pin,
    // Controls
    input wire logic [3:0] battery_threshold_code,
    input wire logic [NBUCK*VCODE_W-1:0] buck_voltage_code,
    input wire logic [NBUCK-1:0] buck_enable,
    input wire logic [NBUCK-1:0] buck_phase_180,
    input wire logic [NBUCK-1:0] buck_fault_irq_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // Multi-step behaviours
    sequence pri_wr_low_s;
        reg_wr && reg_addr == 8'h20 ##1 !voltage_select_pin;
    endsequence
    sequence sec_wr_high_s;
        reg_wr && reg_addr == 8'h21 ##1 voltage_select_pin;
    endsequence
    sequence bat_evt_rd_s;
        battery_event ##1 (reg_rd && reg_addr == 8'h00);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    thr_code_write_a: assert property (reg_wr && reg_addr == 8'h00 |=>
        battery_threshold_code == $past(reg_wdata[3:0])) else $error("threshold code not taken");
    bat_flag_read_a: assert property (bat_evt_rd_s |=> reg_rdata[6])
        else $error("battery flag not read back");
    live_read_a: assert property (reg_rd && reg_addr == 8'h00 |=>
        reg_rdata[5] == $past(battery_low_live)) else $error("live battery bit wrong");
    pri_apply_a: assert property (pri_wr_low_s |->
        buck_voltage_code[11:6] == $past(reg_wdata[5:0])) else $error("primary code not applied");
    sec_apply_a: assert property (sec_wr_high_s |->
        buck_voltage_code[11:6] == $past(reg_wdata[5:0])) else $error("secondary code not applied");
    ctrl_write_a: assert property (reg_wr && reg_addr == 8'h22 |=>
        {buck_enable[1], buck_phase_180[1], buck_fault_irq_enable[1]} == $past({reg_wdata[7], reg_wdata[2:1]}))
        else $error("control bits not taken");
    pok_read_a: assert property (reg_rd && reg_addr == 8'h12 |=>
        reg_rdata[0] == $past(power_ok[0])) else $error("power good bit wrong");
    rsvd_volt_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[7:6] == 2'h0)
        else $error("voltage reserved bits set");
    rsvd_ctrl_a: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata[6:3] == 4'h0)
        else $error("control reserved bits set");
    unmapped_read_a: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind pmusbc_regs pmusbc_regs_chk #(.VCODE_W(VCODE_W), .NBUCK(NBUCK)) chk (.core_clk(core_clk), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .battery_low_live(battery_low_live), .battery_event(battery_event), .power_ok(power_ok),
    .voltage_select_pin(voltage_select_pin), .battery_threshold_code(battery_threshold_code),
    .buck_voltage_code(buck_voltage_code), .buck_enable(buck_enable), .buck_phase_180(buck_phase_180),
    .buck_fault_irq_enable(buck_fault_irq_enable));

// ===== bench/pmusbc_regs_test.sv
// Testbench: register bank driven through the host model.
// Assumes a 250 MHz core clock and synchronous reset.
`timescale 1ns/1ns
module pmusbc_regs_test;
    logic core_clk = 1'b0, reset = 1'b1, reg_wr, reg_rd, battery_low_live = 1'b0, battery_event = 1'b0;
    logic thermal_event = 1'b0, voltage_select_pin = 1'b0, battery_irq, thermal_irq, rd_pend = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_v;
    logic [2:0] power_ok = 3'h0, buck_enable, buck_phase_180, buck_fault_irq_enable;
    logic [3:0] battery_threshold_code;
    logic [17:0] buck_voltage_code;
    logic [31:0] seed = 32'h5103;
    logic [7:0] addr_t[10] = '{8'h00, 8'h01, 8'h10, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32};
    logic [7:0] mask_t[10] = '{8'h9f, 8'hbf, 8'h3f, 8'h86, 8'h3f, 8'h3f, 8'h86, 8'h3f, 8'h3f, 8'h86};
    logic [7:0] wv[10]; // Bytes written per table entry
    int fail_count = 0, compares = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    initial forever #2 core_clk = ~core_clk;
    pmusbc_regs uut (.core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .battery_low_live(battery_low_live),
        .battery_event(battery_event), .thermal_event(thermal_event), .power_ok(power_ok),
        .voltage_select_pin(voltage_select_pin), .battery_threshold_code(battery_threshold_code),
        .battery_irq(battery_irq), .thermal_irq(thermal_irq), .buck_voltage_code(buck_voltage_code),
        .buck_enable(buck_enable), .buck_phase_180(buck_phase_180), .buck_fault_irq_enable(buck_fault_irq_enable));
    pmusbc_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t output value", $time);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read monitor: compares data the cycle after each taken read
    always @(posedge core_clk) begin
        if (rd_pend) begin
            exp_v = host.exp_q.pop_front();
            compares++;
            if (reg_rdata !== exp_v) begin
                fail_count++;
                $display("MISMATCH %0t read data", $time);
            end
        end
        rd_pend = reg_rd && !reset;
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge core_clk);
        fail_count++;
        $display("MISMATCH %0t timeout", $time);
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        // Zero after reset, every mapped register
        for (int i = 0; i < 10; i++) host.rd(addr_t[i], 8'h00);
        // Random writes: only writable bits read back
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            wv[i] = seed[7:0];
            host.wr(addr_t[i], wv[i]);
            host.rd(addr_t[i], wv[i] & mask_t[i]);
        end
        host.wr(8'h11, seed[15:8]);
        host.rd(8'h11, 8'h00);
        chk(battery_threshold_code, wv[0][3:0]);
        chk(buck_enable, {wv[9][7], wv[6][7], wv[3][7]});
        chk(buck_phase_180, {wv[9][2], wv[6][2], wv[3][2]});
        chk(buck_fault_irq_enable, {wv[9][1], wv[6][1], wv[3][1]});
        chk(buck_voltage_code, {wv[7][5:0], wv[4][5:0], wv[2][5:0]});
        @(posedge core_clk) voltage_select_pin <= 1'b1;
        @(posedge core_clk);
        chk(buck_voltage_code, {wv[8][5:0], wv[5][5:0], wv[2][5:0]});
        host.wr(8'h21, 8'hff);
        @(posedge core_clk);
        chk(buck_voltage_code[11:6], 6'h3f);
        host.wr(8'h20, 8'h2a);
        @(posedge core_clk);
        chk(buck_voltage_code[11:6], 6'h3f);
        voltage_select_pin <= 1'b0;
        host.wr(8'h20, 8'h15);
        @(posedge core_clk);
        chk(buck_voltage_code[11:6], 6'h15);
        // Live comparator and power good
        @(posedge core_clk) battery_low_live <= 1'b1;
        power_ok <= 3'h5;
        host.rd(8'h00, (wv[0] & 8'h9f) | 8'h20);
        host.rd(8'h12, (wv[3] & 8'h86) | 8'h01);
        host.rd(8'h22, wv[6] & 8'h86);
        // Events: flags latch, gate the requests, clear on read
        host.wr(8'h00, 8'h80);
        host.wr(8'h01, 8'h00);
        @(posedge core_clk) battery_event <= 1'b1;
        thermal_event <= 1'b1;
        @(posedge core_clk) battery_event <= 1'b0;
        thermal_event <= 1'b0;
        @(posedge core_clk);
        chk({battery_irq, thermal_irq}, 2'b10);
        host.wr(8'h01, 8'h80);
        @(posedge core_clk);
        chk(thermal_irq, 1'b1);
        host.rd(8'h00, 8'he0);
        host.rd(8'h00, 8'ha0);
        host.rd(8'h01, 8'hc0);
        host.rd(8'h01, 8'h80);
        @(posedge core_clk);
        chk({battery_irq, thermal_irq}, 2'b00);
        host.wr(8'h00, 8'h40);
        host.rd(8'h00, 8'h20);
        @(posedge core_clk) battery_event <= 1'b1;
        // Event still high in the clearing read cycle: the set wins
        fork
            host.rd(8'h00, 8'h60);
            repeat (2) @(posedge core_clk);
        join
        battery_event <= 1'b0;
        host.rd(8'h00, 8'h60);
        host.rd(8'h00, 8'h20);
        repeat (3) @(posedge core_clk);
        finish_test();
    end
endmodule

// ===== logic/pmusbc_buck_ctrl.sv
// One step-down regulator's voltage codes and control register.
// Assumes write strobes are already decoded per register.
`timescale 1ns/1ns
module pmusbc_buck_ctrl #(
    parameter int VCODE_W = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register writes
    input wire logic wr_data_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_primary,
    input wire logic wr_secondary,
    input wire logic wr_control,
    // Pin and status inputs
    input wire logic voltage_select_pin,
    input wire logic power_ok_in,
    // Readback
    output logic [7:0] primary_rd,
    output logic [7:0] secondary_rd,
    output logic [7:0] control_rd,
    // Regulator controls
    output logic [VCODE_W-1:0] applied_code,
    output logic enable,
    output logic phase_180,
    output logic fault_irq_enable
);

    logic [VCODE_W-1:0] primary_voltage_code_q;
    logic [VCODE_W-1:0] secondary_voltage_code_q;
    logic enable_q;
    logic phase_q;
    logic fault_en_q;
    logic wr_p;
    logic wr_s;
    logic wr_c;

    // Qualified strobes
    assign wr_p = wr_data_valid & wr_primary;
    assign wr_s = wr_data_valid & wr_secondary;
    assign wr_c = wr_data_valid & wr_control;

    // Voltage code storage, reserved bits never stored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            primary_voltage_code_q <= pmusbc_pkg::RST_VCODE;
            secondary_voltage_code_q <= pmusbc_pkg::RST_VCODE;
        end else begin
            if (wr_p) begin
                primary_voltage_code_q <= wr_data[VCODE_W-1:0];
            end
            if (wr_s) begin
                secondary_voltage_code_q <= wr_data[VCODE_W-1:0];
            end
        end
    end

    // Control bits; power-OK is read-only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_q <= pmusbc_pkg::RST_CTRL[pmusbc_pkg::BIT_ENABLE];
            phase_q <= pmusbc_pkg::RST_CTRL[pmusbc_pkg::BIT_PHASE];
            fault_en_q <= pmusbc_pkg::RST_CTRL[pmusbc_pkg::BIT_FAULT_EN];
        end else if (wr_c) begin
            enable_q <= wr_data[pmusbc_pkg::BIT_ENABLE];
            phase_q <= wr_data[pmusbc_pkg::BIT_PHASE];
            fault_en_q <= wr_data[pmusbc_pkg::BIT_FAULT_EN];
        end
    end

    // Select pin low picks primary, high picks secondary
    assign applied_code = voltage_select_pin ? secondary_voltage_code_q : primary_voltage_code_q;
    assign enable = enable_q;
    assign phase_180 = phase_q;
    assign fault_irq_enable = fault_en_q;

    // Readback, reserved bits read zero
    assign primary_rd = {2'b00, primary_voltage_code_q};
    assign secondary_rd = {2'b00, secondary_voltage_code_q};
    assign control_rd = {enable_q, 4'h0, phase_q, fault_en_q, power_ok_in};

endmodule

// ===== logic/pmusbc_event_flag.sv
// Sticky event flag: set by hardware event, cleared by a host read of its register.
// Assumes event and read strobe are synchronous to core_clk.
`timescale 1ns/1ns
module pmusbc_event_flag (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Event and clear
    input wire logic event_in,
    input wire logic clear_in,
    // Flag
    output logic flag
);

    logic flag_q;
    logic flag_d;

    // Set wins over a clear in the same cycle
    assign flag_d = event_in | (flag_q & ~clear_in);
    assign flag = flag_q;

    // Flag storage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

// ===== logic/pmusbc_pkg.sv
// Package: register map, field positions and reset values of the PMU
// system and step-down regulator control register bank.
// Assumes an 8-bit register address and 8-bit data from the serial bus front end.
package pmusbc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_BATTERY_MONITOR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THERMAL_IRQ_CTRL = 8'h01;
    localparam logic [7:0] ADDR_BUCK1_PRIMARY_VOLTAGE = 8'h10;
    localparam logic [7:0] ADDR_BUCK1_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_BUCK2_PRIMARY_VOLTAGE = 8'h20;
    localparam logic [7:0] ADDR_BUCK2_SECONDARY_VOLTAGE = 8'h21;
    localparam logic [7:0] ADDR_BUCK2_CONTROL = 8'h22;
    localparam logic [7:0] ADDR_BUCK3_PRIMARY_VOLTAGE = 8'h30;
    localparam logic [7:0] ADDR_BUCK3_SECONDARY_VOLTAGE = 8'h31;
    localparam logic [7:0] ADDR_BUCK3_CONTROL = 8'h32;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_UNMASK = 7;
    localparam int BIT_FLAG = 6;
    localparam int BIT_BAT_LIVE = 5;
    localparam int BIT_BAT_RSVD = 4;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PHASE = 2;
    localparam int BIT_FAULT_EN = 1;
    localparam int BIT_POWER_OK = 0;
    localparam int THRESH_W = 4;
    localparam int VCODE_W = 6;
    localparam int SYS_RSVD_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_SYS = 8'h00;
    localparam logic [5:0] RST_VCODE = 6'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_UNMAPPED = 8'h00;

endpackage

// ===== logic/pmusbc_regs.sv
// Top: system and buck 1..3 control register bank of the PMU.
// Assumes a serial bus front end delivering one-cycle read/write strobes
// with an 8-bit address and data, all synchronous to core_clk.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// How it works
// - Sys 0x00 bit7 unmasks battery interrupt
// - Sys 0x00 bit6 reads battery interrupt flag
// - Sys 0x00 bit5 shows live battery-low
// - Sys 0x00 bits3:0 battery threshold code
// - Sys 0x01 bit7 unmasks thermal interrupt
// - Sys 0x01 bit6 reads thermal interrupt flag
// - Primary voltage code bits5:0, 7:6 reserved
// - Buck2/3 use primary code, select low
// - Buck2/3 use secondary code, select high
// - Control bit7 enables the regulator
// - Control bit2 selects 180 degree phase
// - Control bit1 allows fault interrupts
// - Control bit0 reads power-good status
module pmusbc_regs #(
    parameter int VCODE_W = 6,
    parameter int NBUCK = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register access from serial bus front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog monitors and select pin
    input wire logic battery_low_live,
    input wire logic battery_event,
    input wire logic thermal_event,
    input wire logic [NBUCK-1:0] power_ok,
    input wire logic voltage_select_pin,
    // Monitor controls and interrupt requests
    output logic [3:0] battery_threshold_code,
    output logic battery_irq,
    output logic thermal_irq,
    // Regulator controls
    output logic [NBUCK*VCODE_W-1:0] buck_voltage_code,
    output logic [NBUCK-1:0] buck_enable,
    output logic [NBUCK-1:0] buck_phase_180,
    output logic [NBUCK-1:0] buck_fault_irq_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Register map
    //
    // 0x00 battery monitor control
    //   Bit 7: battery unmask, r/w
    //   Bit 6: battery flag, sticky
    //   Bit 5: live battery-low
    //   Bit 4: reserved storage, r/w
    //   Bits 3:0: threshold code, r/w
    //
    // 0x01 thermal control
    //   Bit 7: thermal unmask, r/w
    //   Bit 6: thermal flag, sticky
    //   Bits 5:0: reserved storage, r/w
    //
    // 0xN0 buck N primary code
    //   Bits 7:6: reserved, read zero
    //   Bits 5:0: voltage code, r/w
    //
    // 0xN1 buck N secondary code
    //   Bucks 2 and 3 only
    //   Same layout as primary
    //
    // 0xN2 buck N control
    //   Bit 7: regulator enable
    //   Bits 6:3: reserved, read zero
    //   Bit 2: phase, 1 is 180 degrees
    //   Bit 1: fault interrupt enable
    //   Bit 0: power good, live
    //
    // Other addresses read zero
    // And ignore writes

    // Timing
    //
    // Write lands at its strobe edge
    // Outputs follow at that same edge
    // Read word captured at its edge
    // Held until the next read
    // Read and write of one register
    // In one cycle: old value read

    // Status flags
    //
    // Set by any cycle with event high
    // Cleared by a read of their register
    // Event in the clearing cycle wins
    // So no event slips between reads
    // Mask hides the request only
    // The flag stays readable

    // Voltage select
    //
    // Buck 1 has no secondary code
    // And always applies its primary
    // Bucks 2 and 3 follow the pin
    // Pin taken as synchronous already

    // Host usage
    //
    // Read a stale flag away before
    // Unmasking, or an old event
    // Raises the request at once
    // Program both codes before
    // Moving the select pin

    // Limitations
    //
    // Threshold compare is analog
    // Only its result comes back
    // Power good is not latched
    // A short dip between reads
    // Goes unseen
    // Fault interrupts are raised
    // Outside; only enables live here

    // Read side effects
    //
    // Only system reads clear flags
    // Other reads change no state

    // Reset
    //
    // Every stored field and the read
    // Word clear to zero

    // Parameters
    //
    // VCODE_W: one code's width
    // NBUCK: regulator count, at
    // Most fifteen address rows

    ////////////////////////////////////////////////////////////////////////
    // System register state
    logic battery_level_irq_unmask_q; // Battery interrupt unmask
    logic bat_rsvd_q; // Reserved read/write bit
    logic [3:0] battery_threshold_code_q; // Threshold code
    logic thermal_irq_unmask_q; // Thermal interrupt unmask
    logic [5:0] thermal_rsvd_q; // Reserved read/write bits
    logic battery_level_irq_flag; // Sticky battery flag
    logic thermal_irq_flag; // Sticky thermal flag
    logic [7:0] reg_rdata_q; // Registered read data
    logic [7:0] rdata_d; // Selected read data
    logic [7:0] bat_word; // Battery register as read
    logic [7:0] thm_word; // Thermal register as read

    // Per-regulator readback
    logic [7:0] prim_rd [NBUCK];
    logic [7:0] sec_rd [NBUCK];
    logic [7:0] ctrl_rd [NBUCK];

    // Decodes
    wire hit_bat = (reg_addr == pmusbc_pkg::ADDR_BATTERY_MONITOR_CTRL);
    wire hit_thm = (reg_addr == pmusbc_pkg::ADDR_THERMAL_IRQ_CTRL);
    wire wr_bat = reg_wr & hit_bat;
    wire wr_thm = reg_wr & hit_thm;
    wire rd_bat = reg_rd & hit_bat;
    wire rd_thm = reg_rd & hit_thm;

    // Address of a regulator register: high nibble is regulator, low is slot
    // Shared by write decode and read mux
    function automatic logic buck_hit(input logic [7:0] addr, input int idx, input logic [3:0] slot);
        buck_hit = (addr[7:4] == 4'(idx + 1)) && (addr[3:0] == slot);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // System register writes; status bits are not writable
    // Flag and live bits have no
    // Storage here, so a write to
    // Them simply has no effect
    always_ff @(posedge core_clk) begin
        if (reset) begin
            battery_level_irq_unmask_q <= pmusbc_pkg::RST_SYS[pmusbc_pkg::BIT_UNMASK];
            bat_rsvd_q <= pmusbc_pkg::RST_SYS[pmusbc_pkg::BIT_BAT_RSVD];
            battery_threshold_code_q <= pmusbc_pkg::RST_SYS[3:0];
        end else if (wr_bat) begin
            battery_level_irq_unmask_q <= reg_wdata[pmusbc_pkg::BIT_UNMASK];
            bat_rsvd_q <= reg_wdata[pmusbc_pkg::BIT_BAT_RSVD];
            battery_threshold_code_q <= reg_wdata[3:0];
        end
    end

    // Thermal register writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            thermal_irq_unmask_q <= pmusbc_pkg::RST_SYS[pmusbc_pkg::BIT_UNMASK];
            thermal_rsvd_q <= pmusbc_pkg::RST_SYS[5:0];
        end else if (wr_thm) begin
            thermal_irq_unmask_q <= reg_wdata[pmusbc_pkg::BIT_UNMASK];
            thermal_rsvd_q <= reg_wdata[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags, cleared by reading their register
    // One module keeps the set-over-clear
    // Priority in a single place
    pmusbc_event_flag u_bat_flag (
        .core_clk(core_clk),
        .reset(reset),
        .event_in(battery_event),
        .clear_in(rd_bat),
        .flag(battery_level_irq_flag)
    );

    pmusbc_event_flag u_thm_flag (
        .core_clk(core_clk),
        .reset(reset),
        .event_in(thermal_event),
        .clear_in(rd_thm),
        .flag(thermal_irq_flag)
    );

    // Interrupt requests gated by unmask bits
    assign battery_irq = battery_level_irq_flag & battery_level_irq_unmask_q;
    assign thermal_irq = thermal_irq_flag & thermal_irq_unmask_q;
    assign battery_threshold_code = battery_threshold_code_q;

    // Read words: status bits come from
    // The flag and the live comparator
    assign bat_word = {battery_level_irq_unmask_q, battery_level_irq_flag, battery_low_live,
                       bat_rsvd_q, battery_threshold_code_q};
    assign thm_word = {thermal_irq_unmask_q, thermal_irq_flag, thermal_rsvd_q};

    ////////////////////////////////////////////////////////////////////////
    // Regulators
    // Row N holds buck N: slot 0 primary,
    // Slot 1 secondary, slot 2 control
    // Codes pack six bits a buck,
    // Buck 1 lowest
    genvar gi;
    generate
        for (gi = 0; gi < NBUCK; gi++) begin : g_buck
            wire hit_p = buck_hit(reg_addr, gi, 4'h0);
            wire hit_s = buck_hit(reg_addr, gi, 4'h1) && (gi != 0);
            wire hit_c = buck_hit(reg_addr, gi, 4'h2);
            // Buck 1 has no select pin: it always applies its primary code
            wire sel = (gi != 0) ? voltage_select_pin : 1'b0;
            logic [VCODE_W-1:0] code;
            pmusbc_buck_ctrl #(
                .VCODE_W(VCODE_W)
            ) u_buck (
                .core_clk(core_clk),
                .reset(reset),
                .wr_data_valid(reg_wr),
                .wr_data(reg_wdata),
                .wr_primary(hit_p),
                .wr_secondary(hit_s),
                .wr_control(hit_c),
                .voltage_select_pin(sel),
                .power_ok_in(power_ok[gi]),
                .primary_rd(prim_rd[gi]),
                .secondary_rd(sec_rd[gi]),
                .control_rd(ctrl_rd[gi]),
                .applied_code(code),
                .enable(buck_enable[gi]),
                .phase_180(buck_phase_180[gi]),
                .fault_irq_enable(buck_fault_irq_enable[gi])
            );
            assign buck_voltage_code[gi*VCODE_W +: VCODE_W] = code;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data select; unmapped addresses read zero
    always_comb begin
        rdata_d = pmusbc_pkg::RST_UNMAPPED;
        if (hit_bat) begin
            // Battery word with live status
            rdata_d = bat_word;
        end else if (hit_thm) begin
            // Thermal word with its flag
            rdata_d = thm_word;
        end
        // Rows never overlap, so at most
        // One regulator slot matches
        for (int i = 0; i < NBUCK; i++) begin
            // Primary code slot
            if (buck_hit(reg_addr, i, 4'h0)) begin
                rdata_d = prim_rd[i];
            end
            // Secondary slot, none on buck 1
            if (buck_hit(reg_addr, i, 4'h1) && (i != 0)) begin
                rdata_d = sec_rd[i];
            end
            // Control slot, live power good
            if (buck_hit(reg_addr, i, 4'h2)) begin
                rdata_d = ctrl_rd[i];
            end
        end
    end

    // Read data register, updated on each read strobe
    // Idle cycles leave the word alone,
    // So slow polling sees what it asked
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata_q <= pmusbc_pkg::RST_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // Read data straight from the flop
    assign reg_rdata = reg_rdata_q;

endmodule
